// File: verilog/nsl_pkg.sv
// Package for the network status indicator driver
package nsl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned ACT_BLINK_HZ  = 10;
	localparam int unsigned COL_BLINK_HZ  = 20;
	// Half period in clock cycles, rounded down
	localparam int unsigned ACT_HALF_CYC  = CLK_HZ / (2 * ACT_BLINK_HZ);
	localparam int unsigned COL_HALF_CYC  = CLK_HZ / (2 * COL_BLINK_HZ);
	localparam int unsigned DIV_W         = 24;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFF      = 12'h000;
	localparam logic [11:0] STAT_OFF      = 12'h004;
	localparam int unsigned CTRL_MODE_BIT = 0;
	localparam logic        CTRL_MODE_RST = 1'b0;
	localparam int unsigned STAT_LINK_BIT = 0;
	localparam int unsigned STAT_SPD_BIT  = 1;
	localparam int unsigned STAT_FDX_BIT  = 2;
	localparam int unsigned STAT_COL_BIT  = 3;
	localparam int unsigned STAT_ACT_BIT  = 4;
	localparam int unsigned STAT_LA_BIT   = 5;
	localparam int unsigned STAT_SI_BIT   = 6;
	localparam int unsigned STAT_DC_BIT   = 7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic link_good;
		logic speed_100;
		logic full_duplex;
		logic collision;
		logic activity;
	} nsl_phy_t;

	typedef struct packed {
		logic link_activity_indicator;
		logic speed_indicator;
		logic duplex_collision_indicator;
	} nsl_led_t;

endpackage

// File: verilog/nsl_blink.sv
// Free-running square wave from a clock divider
`timescale 1ns/1ps
module nsl_blink
#(
	parameter int unsigned HALF_CYC = 2
)
(
	input  wire logic clk,
	input  wire logic rstn,
	output logic      wave
);

	logic [nsl_pkg::DIV_W-1:0] cnt_ff;
	logic                      wave_ff;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cnt_ff  <= '0;
			wave_ff <= 1'b0;
		end
		else if (cnt_ff == nsl_pkg::DIV_W'(HALF_CYC - 1))
		begin
			cnt_ff  <= '0;
			wave_ff <= ~wave_ff;
		end
		else
		begin
			cnt_ff <= cnt_ff + nsl_pkg::DIV_W'(1);
		end
	end

	assign wave = wave_ff;

endmodule

// File: verilog/nsl_led_drv.sv
// Network status indicator driver with APB control
// Function
// - Mode one: link LED steady on good link
// - Both modes: link LED blinks 10 Hz on activity
// - Mode one: speed LED on at 100 Mb/s
// - Mode two: speed LED is 100 Mb/s link
// - Mode one: duplex LED steady on full duplex
// - Mode two: duplex LED is 10 Mb/s link
// - Blink timing derived from the block clock
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module nsl_led_drv
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire nsl_pkg::nsl_phy_t phy_status,
	output nsl_pkg::nsl_led_t     leds
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	nsl_pkg::nsl_phy_t sync1_ff;
	nsl_pkg::nsl_phy_t sync2_ff;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= phy_status;
			sync2_ff <= sync1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Blink sources
	// ----------------------------------------------------------------
	logic act_wave;
	logic col_wave;

	nsl_blink #(.HALF_CYC(nsl_pkg::ACT_HALF_CYC)) u_act_blink
	(
		.clk  (clk),
		.rstn (rstn),
		.wave (act_wave)
	);

	nsl_blink #(.HALF_CYC(nsl_pkg::COL_HALF_CYC)) u_col_blink
	(
		.clk  (clk),
		.rstn (rstn),
		.wave (col_wave)
	);

	// ----------------------------------------------------------------
	// Mode register over APB
	// ----------------------------------------------------------------
	logic mode_two_ff;
	logic wr_en;
	logic ctrl_hit;
	logic stat_hit;

	assign ctrl_hit = (paddr == nsl_pkg::CTRL_OFF);
	assign stat_hit = (paddr == nsl_pkg::STAT_OFF);
	assign wr_en    = psel && penable && pwrite && ctrl_hit;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !ctrl_hit && !stat_hit;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			mode_two_ff <= nsl_pkg::CTRL_MODE_RST;
		else if (wr_en)
			mode_two_ff <= pwdata[nsl_pkg::CTRL_MODE_BIT];
	end

	// ----------------------------------------------------------------
	// Indicator decode
	// ----------------------------------------------------------------
	nsl_pkg::nsl_led_t nxt_leds;
	nsl_pkg::nsl_led_t leds_ff;

	always_comb
	begin
		nxt_leds = '0;
		if (sync2_ff.activity)
			nxt_leds.link_activity_indicator = act_wave;
		else if (!mode_two_ff)
			nxt_leds.link_activity_indicator = sync2_ff.link_good;
		if (!mode_two_ff)
		begin
			nxt_leds.speed_indicator = sync2_ff.speed_100;
			if (sync2_ff.full_duplex)
				nxt_leds.duplex_collision_indicator = 1'b1;
			else if (sync2_ff.collision)
				nxt_leds.duplex_collision_indicator = col_wave;
		end
		else
		begin
			nxt_leds.speed_indicator =
				sync2_ff.link_good && sync2_ff.speed_100;
			nxt_leds.duplex_collision_indicator =
				sync2_ff.link_good && !sync2_ff.speed_100;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			leds_ff <= '0;
		else
			leds_ff <= nxt_leds;
	end

	assign leds = leds_ff;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	always_comb
	begin
		nxt_prdata = '0;
		if (ctrl_hit)
			nxt_prdata[nsl_pkg::CTRL_MODE_BIT] = mode_two_ff;
		else if (stat_hit)
		begin
			nxt_prdata[nsl_pkg::STAT_LINK_BIT] = sync2_ff.link_good;
			nxt_prdata[nsl_pkg::STAT_SPD_BIT]  = sync2_ff.speed_100;
			nxt_prdata[nsl_pkg::STAT_FDX_BIT]  = sync2_ff.full_duplex;
			nxt_prdata[nsl_pkg::STAT_COL_BIT]  = sync2_ff.collision;
			nxt_prdata[nsl_pkg::STAT_ACT_BIT]  = sync2_ff.activity;
			nxt_prdata[nsl_pkg::STAT_LA_BIT]   =
				leds_ff.link_activity_indicator;
			nxt_prdata[nsl_pkg::STAT_SI_BIT]   = leds_ff.speed_indicator;
			nxt_prdata[nsl_pkg::STAT_DC_BIT]   =
				leds_ff.duplex_collision_indicator;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			prdata_ff <= '0;
		else if (psel && !penable)
			prdata_ff <= nxt_prdata;
	end

	assign prdata = prdata_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_mode1_link_on: assert property (
		(!mode_two_ff && sync2_ff.link_good && !sync2_ff.activity)
		|=> leds.link_activity_indicator)
		else $error("link indicator not steady on");
	a_act_blink: assert property (
		sync2_ff.activity
		|=> leds.link_activity_indicator == $past(act_wave))
		else $error("activity blink wrong");
	a_mode1_speed: assert property (
		!mode_two_ff |=> leds.speed_indicator == $past(sync2_ff.speed_100))
		else $error("speed indicator wrong in mode one");
	a_mode2_speed: assert property (
		(mode_two_ff && sync2_ff.link_good && sync2_ff.speed_100)
		|=> leds.speed_indicator)
		else $error("100 link indicator off");
	a_mode1_fdx: assert property (
		(!mode_two_ff && sync2_ff.full_duplex)
		|=> leds.duplex_collision_indicator)
		else $error("full duplex indicator off");
	a_mode1_col: assert property (
		(!mode_two_ff && !sync2_ff.full_duplex && sync2_ff.collision)
		|=> leds.duplex_collision_indicator == $past(col_wave))
		else $error("collision blink wrong");
	a_mode2_ten: assert property (
		(mode_two_ff && sync2_ff.link_good && !sync2_ff.speed_100)
		|=> leds.duplex_collision_indicator && !leds.speed_indicator)
		else $error("10 link indicator wrong");
	a_mode_write: assert property (
		wr_en |=> mode_two_ff == $past(pwdata[nsl_pkg::CTRL_MODE_BIT]))
		else $error("mode write lost");
	a_col_period: assert property (
		$rose(col_wave) |=> !$rose(col_wave) [*8])
		else $error("collision wave too fast");
	a_mode2_act_only: assert property (
		(mode_two_ff && !sync2_ff.activity)
		|=> !leds.link_activity_indicator)
		else $error("link indicator lit without activity");
	a_bad_write: assert property (
		(psel && penable && pwrite && !ctrl_hit)
		|=> $stable(mode_two_ff))
		else $error("mode changed by stray write");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	c_mode_two: cover property (wr_en && pwdata[0]);
	c_act_blink: cover property (sync2_ff.activity && $rose(act_wave));
	c_collision: cover property (!mode_two_ff && sync2_ff.collision);
	c_ten_link: cover property (mode_two_ff && sync2_ff.link_good
		&& !sync2_ff.speed_100);
	c_bad_addr: cover property (pslverr);

endmodule

// File: bench/nsl_led_board.sv
// Board lamps driven by the indicator outputs
`timescale 1ns/1ps
module nsl_led_board
(
	input  wire nsl_pkg::nsl_led_t leds,
	output logic [2:0]             lamp_on
);
	// ----------------------------------------------------------------
	// Lamps
	// ----------------------------------------------------------------
	// Active high drive lights a lamp
	assign lamp_on = leds;
endmodule

// File: bench/nsl_led_drv_bench.sv
// Self-checking bench for the status indicator driver
`timescale 1ns/1ps
module nsl_led_drv_bench;
	logic              clk;
	logic              rstn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	nsl_pkg::nsl_phy_t phy;
	nsl_pkg::nsl_led_t leds;
	logic [2:0]        lamp;
	logic [31:0]       rd;
	logic              err;
	int                num_errors;
	int                samples_checked;
	int                cyc;

	nsl_led_drv i_nsl_led_drv
	(
		.clk        (clk),
		.rstn       (rstn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.phy_status (phy),
		.leds       (leds)
	);

	nsl_led_board i_nsl_led_board
	(
		.leds    (leds),
		.lamp_on (lamp)
	);

	// ----------------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------------
	always #4 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task test_done();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task led(input logic [4:0] p, input logic [2:0] e);
		@(posedge clk);
		phy <= p;
		repeat (5) @(posedge clk);
		chk({29'h0000_0000, lamp}, {29'h0000_0000, e});
	endtask

	task t_regs();
		apb(1'b0, nsl_pkg::CTRL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 12'h008, 32'h0000_0001);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b1, nsl_pkg::STAT_OFF, 32'h0000_0001);
		chk({31'h0000_0000, err}, 32'h0000_0000);
		apb(1'b1, nsl_pkg::CTRL_OFF, 32'hFFFF_FFFE);
		apb(1'b0, nsl_pkg::CTRL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask

	task t_mode_one();
		led(5'h1C, 3'b111);
		apb(1'b0, nsl_pkg::STAT_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00E7);
		led(5'h1E, 3'b111);
		led(5'h10, 3'b100);
		led(5'h08, 3'b010);
		led(5'h12, 3'b100);
		led(5'h11, 3'b000);
	endtask

	task t_mode_two();
		apb(1'b1, nsl_pkg::CTRL_OFF, 32'h0000_0001);
		apb(1'b0, nsl_pkg::CTRL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		led(5'h18, 3'b010);
		led(5'h1C, 3'b010);
		led(5'h10, 3'b001);
		led(5'h00, 3'b000);
		led(5'h19, 3'b010);
		apb(1'b1, nsl_pkg::CTRL_OFF, 32'h0000_0000);
		led(5'h1C, 3'b111);
	endtask

	task t_reset();
		apb(1'b1, nsl_pkg::CTRL_OFF, 32'h0000_0001);
		led(5'h18, 3'b010);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({29'h0000_0000, lamp}, 32'h0000_0000);
		apb(1'b0, nsl_pkg::CTRL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		led(5'h18, 3'b110);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		phy = 5'h00;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_mode_one();
		t_mode_two();
		t_reset();
		test_done();
	end
endmodule
